// file: rtl/serdes_analog_page.sv
// serializer analog page registers, bank resets and lane start-up control
// assumes an avalon-mm master holding requests until waitrequest is low
// What this block does
// - route bit puts overrange flag on pin
// - pin enable overrides powerdown; else route ignored
// - three-bit swing code, all lanes, default zero
// - hardware reset returns all registers to default
// - 81h resets analog pages, bit self-clears
// - host selects bank page by code
// - host clears unused pages at init
// - 01h resets jesd bank, self-clearing
// - main page settings apply after pulse
// - 80h enables k override both channels
// - sync low sends k28.5 continuously
// - sync high starts ila then data
// - reset default 20x, lmfs 8224, no decimation
// - multiplier mode 00 20x, 10 40x
`timescale 1ns/1ps
module serdes_analog_page (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        fast_overrange_flag,
  input  wire logic        powerdown_request,
  input  wire logic        sync_n,
  input  wire logic [7:0]  sample_data,
  output logic             powerdown_pin,
  output logic [2:0]       transmitter_swing_code,
  output logic             serializer_pll_reset,
  output logic [1:0]       serializer_multiplier_mode,
  output logic [7:0]       lane_data,
  output logic             lane_is_k
);
  typedef enum {st_idle, st_ack} bus_state_t;
  typedef enum {ln_sync, ln_ila, ln_data} lane_state_t;

  bus_state_t  bus_reg, bus_next;
  lane_state_t lane_reg, lane_next;
  logic [7:0]  pll_reg, pll_next;
  logic [7:0]  route_reg, route_next;
  logic [7:0]  swing_reg, swing_next;
  logic [7:0]  page_reg, page_next;
  logic [4:0]  k_reg, k_next;
  logic [4:0]  k_live_reg, k_live_next;
  logic        k_ovr_reg, k_ovr_next;
  logic [1:0]  mode_reg, mode_next;
  logic [1:0]  mode_live_reg, mode_live_next;
  logic        apply_reg, apply_next;
  logic        bank_rst_reg, bank_rst_next;
  logic        ana_rst_reg, ana_rst_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0]  out_reg, out_next;
  logic        outk_reg, outk_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic [7:0]  mem_rdata;
  logic [7:0]  idx;
  logic        wr_go;
  logic [7:0]  wbyte;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction : hit

  assign idx   = avs_address[9:2];
  assign wbyte = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
  // a write lands only on the edge where waitrequest is seen low
  assign wr_go = avs_write && bus_reg == st_ack && avs_byteenable[0];
  assign avs_waitrequest = (avs_read || avs_write) && bus_reg == st_idle;
  assign avs_readdata    = rdata_reg;

  // ila pattern memory, never written (write enable tied low); its read data goes unused
  lane_char_mem #(.DEPTH(16), .AW(4)) u_ila (
    .clk   (clk),
    .we    (1'b0),
    .waddr (4'h0),
    .wdata (8'h00),
    .raddr (cnt_reg),
    .rdata (mem_rdata)
  );

  always_comb begin
    bus_next       = bus_reg;
    pll_next       = pll_reg;
    route_next     = route_reg;
    swing_next     = swing_reg;
    page_next      = page_reg;
    k_next         = k_reg;
    k_ovr_next     = k_ovr_reg;
    mode_next      = mode_reg;
    k_live_next    = k_live_reg;
    mode_live_next = mode_live_reg;
    apply_next     = apply_reg;
    bank_rst_next  = 1'b0;
    ana_rst_next   = 1'b0;
    rdata_next     = rdata_reg;
    case (bus_reg)
      st_idle: begin
        if (avs_read || avs_write) begin
          bus_next = st_ack;
        end
      end
      st_ack: bus_next = st_idle;
      default: bus_next = st_idle;
    endcase
    if (wr_go) begin
      case (idx)
        serdes_page_pkg::idx_pll_reset:
          pll_next = wbyte & serdes_page_pkg::mask_pll_reset;
        serdes_page_pkg::idx_route_select:
          route_next = wbyte & serdes_page_pkg::mask_route;
        serdes_page_pkg::idx_swing_enable:
          swing_next = wbyte & serdes_page_pkg::mask_swing_en;
        serdes_page_pkg::idx_page_select: page_next = wbyte;
        serdes_page_pkg::idx_k_value: k_next = wbyte[4:0];
        serdes_page_pkg::idx_link_control: mode_next = wbyte[1:0];
        serdes_page_pkg::idx_bank_command: begin
          if (hit(wbyte, serdes_page_pkg::cmd_analog_reset)) begin
            ana_rst_next = 1'b1;
          end else if (hit(page_reg, serdes_page_pkg::page_main)) begin
            if (hit(wbyte, serdes_page_pkg::cmd_bank_reset)) begin
              bank_rst_next = 1'b1;
            end
          end else if (hit(page_reg, serdes_page_pkg::page_jesd_dig)) begin
            k_ovr_next = hit(wbyte, serdes_page_pkg::cmd_k_override);
          end
        end
        serdes_page_pkg::idx_mode_status: begin
          // falling edge of the apply bit commits the main page
          if (apply_reg && !wbyte[0]) begin
            mode_live_next = mode_reg;
            k_live_next    = k_reg;
          end
          apply_next = hit(wbyte, serdes_page_pkg::cmd_apply);
        end
        default: ; // unused pages hold nothing here
      endcase
    end
    if (ana_rst_reg) begin
      pll_next   = serdes_page_pkg::reset_reg_value;
      route_next = serdes_page_pkg::reset_reg_value;
      swing_next = serdes_page_pkg::reset_reg_value;
    end
    if (bank_rst_reg) begin
      page_next      = serdes_page_pkg::reset_reg_value;
      k_next         = serdes_page_pkg::reset_k_value;
      k_ovr_next     = 1'b0;
      mode_next      = serdes_page_pkg::mode_20x;
      mode_live_next = serdes_page_pkg::mode_20x;
      k_live_next    = serdes_page_pkg::reset_k_value;
      apply_next     = 1'b0;
      // the analog page of the link sits in this bank as well
      pll_next       = serdes_page_pkg::reset_reg_value;
      route_next     = serdes_page_pkg::reset_reg_value;
      swing_next     = serdes_page_pkg::reset_reg_value;
    end
    if (avs_read && bus_reg == st_idle) begin
      case (idx)
        serdes_page_pkg::idx_pll_reset:    rdata_next = {24'h0, pll_reg};
        serdes_page_pkg::idx_route_select: rdata_next = {24'h0, route_reg};
        serdes_page_pkg::idx_swing_enable: rdata_next = {24'h0, swing_reg};
        serdes_page_pkg::idx_page_select:  rdata_next = {24'h0, page_reg};
        serdes_page_pkg::idx_k_value:      rdata_next = {27'h0, k_reg};
        serdes_page_pkg::idx_link_control: rdata_next = {30'h0, mode_reg};
        serdes_page_pkg::idx_link_status:
          rdata_next = {serdes_page_pkg::lmfs_default, 8'h00,
                        k_ovr_reg, k_live_reg, lane_reg == ln_data,
                        mode_live_reg[1]};
        default: rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_reg       <= st_idle;
      pll_reg       <= serdes_page_pkg::reset_reg_value;
      route_reg     <= serdes_page_pkg::reset_reg_value;
      swing_reg     <= serdes_page_pkg::reset_reg_value;
      page_reg      <= serdes_page_pkg::reset_reg_value;
      k_reg         <= serdes_page_pkg::reset_k_value;
      k_live_reg    <= serdes_page_pkg::reset_k_value;
      k_ovr_reg     <= 1'b0;
      mode_reg      <= serdes_page_pkg::mode_20x;
      mode_live_reg <= serdes_page_pkg::mode_20x;
      apply_reg     <= 1'b0;
      bank_rst_reg  <= 1'b0;
      ana_rst_reg   <= 1'b0;
      rdata_reg     <= 32'h0;
    end else begin
      bus_reg       <= bus_next;
      pll_reg       <= pll_next;
      route_reg     <= route_next;
      swing_reg     <= swing_next;
      page_reg      <= page_next;
      k_reg         <= k_next;
      k_live_reg    <= k_live_next;
      k_ovr_reg     <= k_ovr_next;
      mode_reg      <= mode_next;
      mode_live_reg <= mode_live_next;
      apply_reg     <= apply_next;
      bank_rst_reg  <= bank_rst_next;
      ana_rst_reg   <= ana_rst_next;
      rdata_reg     <= rdata_next;
    end
  end

  // lane sequencing: comma while sync is low, short ila, then samples
  always_comb begin
    lane_next = lane_reg;
    cnt_next  = cnt_reg;
    out_next  = serdes_page_pkg::k28_5_code;
    outk_next = 1'b1;
    case (lane_reg)
      ln_sync: begin
        cnt_next = 4'h0;
        if (sync_n) begin
          lane_next = ln_ila;
        end
      end
      ln_ila: begin
        out_next = serdes_page_pkg::ila_marker;
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == serdes_page_pkg::ila_frames - 4'h1) begin
          lane_next = ln_data;
        end
      end
      ln_data: begin
        out_next  = sample_data;
        outk_next = 1'b0;
      end
      default: lane_next = ln_sync;
    endcase
    if (!sync_n) begin
      lane_next = ln_sync;
      out_next  = serdes_page_pkg::k28_5_code;
      outk_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lane_reg <= ln_sync;
      cnt_reg  <= 4'h0;
      out_reg  <= serdes_page_pkg::k28_5_code;
      outk_reg <= 1'b1;
    end else begin
      lane_reg <= lane_next;
      cnt_reg  <= cnt_next;
      out_reg  <= out_next;
      outk_reg <= outk_next;
    end
  end

  assign lane_data  = out_reg;
  assign lane_is_k  = outk_reg;
  // memory read unused for data path; ila marker is the fixed constant
  // combinational mux so the overrange flag reaches the pin without lag
  assign powerdown_pin = swing_reg[serdes_page_pkg::pin_enable_bit]
      ? (route_reg[serdes_page_pkg::route_bit] & fast_overrange_flag)
      : powerdown_request;
  assign transmitter_swing_code =
      swing_reg[7:serdes_page_pkg::swing_lsb];
  assign serializer_pll_reset =
      pll_reg[serdes_page_pkg::pll_reset_bit];
  assign serializer_multiplier_mode = mode_live_reg;

  a_swing_follows: assert property (@(posedge clk) disable iff (sys_rst)
    wr_go && idx == serdes_page_pkg::idx_swing_enable && !ana_rst_reg &&
    !bank_rst_reg |=> transmitter_swing_code == $past(avs_writedata[7:5]))
    else $error("swing code mismatch");
  a_sync_comma: assert property (@(posedge clk) disable iff (sys_rst)
    !sync_n |=> lane_is_k && lane_data == 8'hbc)
    else $error("no comma while sync low");
  sequence s_sync_released;
    lane_reg == ln_sync && sync_n ##1 sync_n[*4];
  endsequence
  a_ila_then_data: assert property (@(posedge clk) disable iff (sys_rst)
    s_sync_released |=> lane_reg == ln_data)
    else $error("ila did not end in data");
  a_pin_override: assert property (@(posedge clk) disable iff (sys_rst)
    !swing_reg[3] |-> powerdown_pin == powerdown_request)
    else $error("pin not normal when disabled");
  a_route_flag: assert property (@(posedge clk) disable iff (sys_rst)
    swing_reg[3] && route_reg[1] |-> powerdown_pin == fast_overrange_flag)
    else $error("overrange not routed");
  a_bank_clears: assert property (@(posedge clk) disable iff (sys_rst)
    bank_rst_reg |=> !bank_rst_reg && k_reg == 5'h08 && !k_ovr_reg &&
    swing_reg == 8'h00)
    else $error("bank reset not self clearing");
  a_ana_clears: assert property (@(posedge clk) disable iff (sys_rst)
    ana_rst_reg |=> !ana_rst_reg && swing_reg == 8'h00)
    else $error("analog reset not applied");
  a_apply_commit: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(mode_live_reg) |-> $past(apply_reg) || $past(bank_rst_reg))
    else $error("mode changed without apply");
endmodule : serdes_analog_page

// file: rtl/serdes_page_pkg.sv
// constants for the serializer analog page register block
// assumes a byte-wide register map reached over a 32-bit avalon-mm slave
package serdes_page_pkg;
  // register indexes (byte address is 4x the index)
  localparam logic [7:0] idx_pll_reset    = 8'h17;
  localparam logic [7:0] idx_route_select = 8'h1a;
  localparam logic [7:0] idx_swing_enable = 8'h1b;
  localparam logic [7:0] idx_link_status  = 8'h20;
  localparam logic [7:0] idx_link_control = 8'h21;
  localparam logic [7:0] idx_bank_command = 8'h22;
  localparam logic [7:0] idx_page_select  = 8'h23;
  localparam logic [7:0] idx_k_value      = 8'h24;
  localparam logic [7:0] idx_mode_status  = 8'h25;
  // field positions
  localparam int pll_reset_bit   = 6;
  localparam int route_bit       = 1;
  localparam int pin_enable_bit  = 3;
  localparam int swing_lsb       = 5;
  // writable masks; reserved bits read as zero
  localparam logic [7:0] mask_pll_reset   = 8'h40;
  localparam logic [7:0] mask_route       = 8'h02;
  localparam logic [7:0] mask_swing_en    = 8'he8;
  // reset values
  localparam logic [7:0] reset_reg_value  = 8'h00;
  localparam logic [4:0] reset_k_value    = 5'h08;
  localparam logic [1:0] mode_20x         = 2'b00;
  localparam logic [1:0] mode_40x         = 2'b10;
  localparam logic [15:0] lmfs_default    = 16'h8224;
  // bank commands and page codes
  localparam logic [7:0] cmd_analog_reset = 8'h81;
  localparam logic [7:0] cmd_bank_reset   = 8'h01;
  localparam logic [7:0] cmd_apply        = 8'h01;
  localparam logic [7:0] cmd_k_override   = 8'h80;
  localparam logic [7:0] page_main        = 8'h68;
  localparam logic [7:0] page_jesd_dig    = 8'h69;
  localparam logic [7:0] page_jesd_ana    = 8'h6a;
  // 8b/10b comma and ila length
  localparam logic [7:0] k28_5_code       = 8'hbc;
  localparam logic [3:0] ila_frames       = 4'h4;
  localparam logic [7:0] ila_marker       = 8'h1c;
endpackage : serdes_page_pkg

// file: rtl/lane_char_mem.sv
// small ila pattern store with registered read data
// assumes a single clock and synchronous writes from the register side
`timescale 1ns/1ps
module lane_char_mem #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [DEPTH];

  // no reset on the array; mem[raddr] is read every cycle, written or not
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : lane_char_mem

// file: test/sync_receiver_model.sv
// receiver model: holds sync low until it has seen enough commas
// assumes lane outputs are registered on the block clock
`timescale 1ns/1ps
module sync_receiver_model #(
  parameter int COMMAS_NEEDED = 4
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] lane_data,
  input  wire logic       lane_is_k,
  input  wire logic       resync,
  output logic            sync_n
);
  int comma_cnt;
  // a real receiver needs a run of commas, not a single one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_n    <= 1'b0;
      comma_cnt <= 0;
    end else if (resync) begin
      sync_n    <= 1'b0;
      comma_cnt <= 0;
    end else if (!sync_n) begin
      if (lane_is_k === 1'b1 && lane_data === serdes_page_pkg::k28_5_code)
        comma_cnt <= comma_cnt + 1;
      else
        comma_cnt <= 0;
      if (comma_cnt >= COMMAS_NEEDED)
        sync_n <= 1'b1;
    end
  end
endmodule : sync_receiver_model

// file: test/serdes_analog_page_bench.sv
// bench for the serializer analog page block
// assumes a 25 mhz clock and an avalon-mm slave with waitrequest
`timescale 1ns/1ps
module serdes_analog_page_bench;
  logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest, resync;
  logic        fast_overrange_flag, powerdown_request, sync_n, lane_is_k;
  logic        powerdown_pin, serializer_pll_reset;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable;
  logic [7:0]  sample_data, lane_data;
  logic [2:0]  transmitter_swing_code;
  logic [1:0]  serializer_multiplier_mode;
  int          mismatches, checks, n, cnt;
  typedef struct {logic [7:0] idx, wd, rexp; logic [2:0] sw; logic pll;} row_t;
  row_t        rows[12];

  serdes_analog_page i_serdes_analog_page (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fast_overrange_flag(fast_overrange_flag),
    .powerdown_request(powerdown_request), .sync_n(sync_n),
    .sample_data(sample_data), .powerdown_pin(powerdown_pin),
    .transmitter_swing_code(transmitter_swing_code),
    .serializer_pll_reset(serializer_pll_reset),
    .serializer_multiplier_mode(serializer_multiplier_mode),
    .lane_data(lane_data), .lane_is_k(lane_is_k));
  sync_receiver_model i_sync_receiver_model (.clk(clk), .sys_rst(sys_rst),
    .lane_data(lane_data), .lane_is_k(lane_is_k), .resync(resync),
    .sync_n(sync_n));

  task automatic end_sim;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  // one access; request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      mismatches++;
      end_sim();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    chk_val(rd, exp);
  endtask : rd_chk

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  initial begin
    sys_rst = 1'b1; avs_address = '0; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = '0; avs_byteenable = 4'h1; resync = 1'b0;
    fast_overrange_flag = 1'b0; powerdown_request = 1'b0;
    sample_data = 8'h5a;
    rows[0] = '{serdes_page_pkg::idx_pll_reset, 8'h40, 8'h40, 3'h0, 1'b1};
    rows[1] = '{serdes_page_pkg::idx_pll_reset, 8'h00, 8'h00, 3'h0, 1'b0};
    for (int k = 0; k < 8; k++) begin
      rows[k+2] = '{serdes_page_pkg::idx_swing_enable, {3'(k), 5'h0},
                    {3'(k), 5'h0}, 3'(k), 1'b0};
    end
    rows[10] = '{serdes_page_pkg::idx_route_select, 8'h02, 8'h02, 3'h7, 1'b0};
    rows[11] = '{serdes_page_pkg::idx_swing_enable, 8'h08, 8'h08, 3'h0, 1'b0};
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(serdes_page_pkg::idx_swing_enable, 32'h0);
    rd_chk(serdes_page_pkg::idx_k_value, 32'h8);
    bus(1'b0, serdes_page_pkg::idx_link_status, 8'h00);
    chk_val(rd[31:16], serdes_page_pkg::lmfs_default);
    chk_val(serializer_multiplier_mode, serdes_page_pkg::mode_20x);
    // writes meant for other pages must leave nothing behind here
    bus(1'b1, 8'h01, 8'h00);
    bus(1'b1, 8'h02, 8'h00);
    bus(1'b1, 8'h11, 8'h80);
    bus(1'b1, 8'h59, 8'h20);
    bus(1'b1, 8'h39, 8'hc0);
    bus(1'b1, 8'h3a, 8'h40);
    bus(1'b1, 8'h56, 8'h04);
    rd_chk(8'h59, 32'h0);
    rd_chk(8'h3f, 32'h0);
    // pll pulse, every swing code, then route and pin enable
    foreach (rows[i]) begin
      bus(1'b1, rows[i].idx, rows[i].wd);
      rd_chk(rows[i].idx, {24'h0, rows[i].rexp});
      chk_val(transmitter_swing_code, rows[i].sw);
      chk_val(serializer_pll_reset, rows[i].pll);
    end
    for (int v = 0; v < 4; v++) begin
      if (v == 2) bus(1'b1, serdes_page_pkg::idx_swing_enable, 8'h00);
      fast_overrange_flag <= v[0];
      powerdown_request   <= !v[0];
      repeat (2) @(posedge clk);
      chk_val(powerdown_pin, (v < 2) ? v[0] : !v[0]);
    end
    bus(1'b1, serdes_page_pkg::idx_bank_command, 8'h81);
    rd_chk(serdes_page_pkg::idx_route_select, 32'h0);
    bus(1'b1, serdes_page_pkg::idx_page_select, serdes_page_pkg::page_main);
    bus(1'b1, serdes_page_pkg::idx_link_control, 8'h02);
    bus(1'b1, serdes_page_pkg::idx_k_value, 8'h0f);
    chk_val(serializer_multiplier_mode, serdes_page_pkg::mode_20x);
    bus(1'b1, serdes_page_pkg::idx_mode_status, 8'h01);
    bus(1'b1, serdes_page_pkg::idx_mode_status, 8'h00);
    chk_val(serializer_multiplier_mode, serdes_page_pkg::mode_40x);
    bus(1'b0, serdes_page_pkg::idx_link_status, 8'h00);
    chk_val({rd[6:2], rd[0]}, {5'h0f, 1'b1});
    bus(1'b1, serdes_page_pkg::idx_page_select, 8'h69);
    bus(1'b1, serdes_page_pkg::idx_bank_command, 8'h80);
    bus(1'b0, serdes_page_pkg::idx_link_status, 8'h00);
    chk_val(rd[7], 1'b1);
    bus(1'b1, serdes_page_pkg::idx_page_select, 8'h68);
    bus(1'b1, serdes_page_pkg::idx_swing_enable, 8'he8);
    bus(1'b1, serdes_page_pkg::idx_bank_command, 8'h01);
    rd_chk(serdes_page_pkg::idx_swing_enable, 32'h0);
    rd_chk(serdes_page_pkg::idx_k_value, 32'h8);
    // comma phase, then ila frames, then sample data
    resync <= 1'b1;
    @(posedge clk);
    resync <= 1'b0;
    repeat (3) @(posedge clk);
    chk_val({lane_is_k, lane_data}, {1'b1, 8'hbc});
    cnt = 0;
    for (int c = 0; c < 40 && lane_is_k !== 1'b0; c++) begin
      @(posedge clk);
      if (lane_is_k === 1'b1 && lane_data === 8'h1c) cnt++;
    end
    chk_val(cnt, 4);
    chk_val({lane_is_k, lane_data}, {1'b0, 8'h5a});
    bus(1'b1, serdes_page_pkg::idx_swing_enable, 8'he8);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk_val({lane_is_k, lane_data}, {1'b1, 8'hbc});
    repeat (2) @(posedge clk);
    rd_chk(serdes_page_pkg::idx_swing_enable, 32'h0);
    chk_val(serializer_multiplier_mode, serdes_page_pkg::mode_20x);
    end_sim();
  end
endmodule : serdes_analog_page_bench
